// [rtl/fsg_pkg.sv]
// Shared constants and carrier types for the flash security gate
package fsg_pkg;
  // APB register byte offsets
  localparam logic [7:0]  OFF_STATUS   = 8'h00;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h08;
  // Status register field positions
  localparam int          STAT_ACTIVE_LSB = 0;
  localparam int          STAT_STORED_LSB = 4;
  localparam int          STAT_BUSY_BIT   = 8;
  // Lock bit positions inside a four-bit lock vector
  localparam int          LOCK_CHIP  = 0;
  localparam int          LOCK_BLOCK = 1;
  localparam int          LOCK_WRITE = 2;
  localparam int          LOCK_BOOT  = 3;
  // Interrupt event bit positions
  localparam int          IRQ_REFUSED = 0;
  localparam int          IRQ_DONE    = 1;
  localparam int          IRQ_LOCKSET = 2;
  // Values after reset
  localparam logic [3:0]  LOCK_RESET   = 4'h0;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;
  // Last address of the protected boot region
  localparam logic [15:0] BOOT_LAST    = 16'h0FFF;

  typedef enum logic [1:0] {
    FSG_OP_CHIP,
    FSG_OP_BLOCK,
    FSG_OP_WRITE,
    FSG_OP_SECSET
  } fsg_op_type;

  typedef struct packed {
    logic       selfPath;
    fsg_op_type op;
    logic [15:0] addr;
    logic [3:0] locks;
  } fsg_cmd_type;

  typedef struct packed {
    logic       go;
    fsg_op_type op;
    logic [15:0] addr;
  } fsg_flash_type;

  typedef struct packed {
    logic valid;
    logic error;
  } fsg_resp_type;
endpackage

// [rtl/fsg_lock_store.sv]
// Persistent lock settings store
`timescale 1ns/1ps
`default_nettype none
module fsg_lock_store
  import fsg_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Update requests
  input  wire logic [3:0] setMask,
  input  wire logic       clearEraseLocks,
  // Stored settings
  output logic [3:0]      stored
);

  logic [3:0] next_stored;

  // Bits may only be set; the only clear is of block and write locks, never once chip lock is set
  always_comb begin
    next_stored = stored | setMask;
    if (clearEraseLocks && !stored[LOCK_CHIP]) begin
      next_stored[LOCK_BLOCK] = setMask[LOCK_BLOCK];
      next_stored[LOCK_WRITE] = setMask[LOCK_WRITE];
    end
  end

  // Delivered state has every lock clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stored <= LOCK_RESET;
    end else begin
      stored <= next_stored;
    end
  end

  a_chip_lock_perm: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stored[LOCK_CHIP] |=> stored == ($past(stored) | $past(setMask)))
    else $error("lock cleared while chip lock set");
  a_boot_lock_perm: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stored[LOCK_BOOT] |=> stored[LOCK_BOOT])
    else $error("boot lock cleared");
endmodule
`default_nettype wire

// [rtl/fsg_gate.sv]
// Flash security gate: lock checking, command sequencing and APB registers
//
// Function
// - New settings apply at next programming entry
// - Chip lock refuses programmer chip/block erase
// - Chip lock makes every lock permanent
// - Block lock refuses programmer block erase
// - Block lock spares self-path block erase
// - Write lock refuses programmer write, block erase
// - Write lock spares self-path writes
// - Boot lock refuses chip erase, boot writes
// - Boot lock also guards self-path boot region
// - All locks clear in delivered state
// - Both paths set independent lock bits
// - Chip erase clears block, write locks
// - Block/write locks still allow chip erase
// - Only programmer chip erase clears those locks
// - Boot lock can never be cleared
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsg_gate
  import fsg_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Programming mode entry pin
  input  wire logic          progEntryPin,
  // Command port from programmer transport and self-programming path
  input  wire logic          cmdValid,
  input  wire fsg_cmd_type   cmd,
  output logic               cmdReady,
  output fsg_resp_type       resp,
  // Flash cell engine
  output fsg_flash_type      flashReq,
  input  wire logic          flashDone,
  input  wire logic          flashOk,
  // Interrupt
  output logic               irq
);

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } fsg_state_type;

  fsg_state_type state;
  fsg_state_type next_state;
  logic [3:0]    active;
  logic [3:0]    stored;
  logic [3:0]    setMask;
  logic          clearEraseLocks;
  logic          entrySync1;
  logic          entrySync2;
  logic          entryPrev;
  logic          entryRise;
  logic          accept;
  logic          bootHit;
  logic          refuse;
  logic          execOp;
  fsg_op_type    execOpCode;
  logic          execSelf;
  logic [2:0]    irqStat;
  logic [2:0]    irqMask;
  logic [2:0]    irqEvent;
  logic          apbAccess;
  logic          apbCommit;
  logic          apbHit;

  fsg_lock_store u_store (
    .sys_clk         (sys_clk),
    .rst_b           (rst_b),
    .setMask         (setMask),
    .clearEraseLocks (clearEraseLocks),
    .stored          (stored)
  );

  // Entry pin is asynchronous to sys_clk; second stage feeds the edge detector
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      entrySync1 <= 1'b0;
      entrySync2 <= 1'b0;
      entryPrev  <= 1'b0;
    end else begin
      entrySync1 <= progEntryPin;
      entrySync2 <= entrySync1;
      entryPrev  <= entrySync2;
    end
  end

  assign entryRise = entrySync2 && !entryPrev;
  assign accept    = cmdValid && cmdReady;
  assign bootHit   = cmd.addr <= BOOT_LAST;

  // Permission decision against the settings latched at programming entry
  always_comb begin
    refuse = 1'b0;
    case (cmd.op)
      FSG_OP_CHIP: begin
        if (cmd.selfPath) begin
          refuse = 1'b1;
        end else begin
          refuse = active[LOCK_CHIP] || active[LOCK_BOOT];
        end
      end
      FSG_OP_BLOCK: begin
        if (cmd.selfPath) begin
          refuse = active[LOCK_BOOT] && bootHit;
        end else begin
          refuse = active[LOCK_CHIP] || active[LOCK_BLOCK] || active[LOCK_WRITE]
                   || (active[LOCK_BOOT] && bootHit);
        end
      end
      FSG_OP_WRITE: begin
        if (cmd.selfPath) begin
          refuse = active[LOCK_BOOT] && bootHit;
        end else begin
          refuse = active[LOCK_WRITE] || (active[LOCK_BOOT] && bootHit);
        end
      end
      FSG_OP_SECSET: refuse = 1'b0;
      default:       refuse = 1'b1;
    endcase
  end

  // Security set only writes the store; chip erase success clears erase locks
  assign setMask         = (accept && cmd.op == FSG_OP_SECSET) ? cmd.locks : 4'h0;
  assign clearEraseLocks = state == ST_EXEC && flashDone && flashOk
                           && execOpCode == FSG_OP_CHIP && !execSelf;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept && !refuse && cmd.op != FSG_OP_SECSET) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (flashDone) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      cmdReady <= 1'b0;
    end else begin
      state    <= next_state;
      cmdReady <= next_state == ST_IDLE;
    end
  end

  // Remember what is running so completion can be judged
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      execOpCode <= FSG_OP_CHIP;
      execSelf   <= 1'b0;
    end else if (accept) begin
      execOpCode <= cmd.op;
      execSelf   <= cmd.selfPath;
    end
  end

  // Refused commands never reach the flash engine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flashReq <= '0;
    end else begin
      flashReq.go   <= accept && !refuse && cmd.op != FSG_OP_SECSET;
      flashReq.op   <= accept ? cmd.op : flashReq.op;
      flashReq.addr <= accept ? cmd.addr : flashReq.addr;
    end
  end

  assign execOp = accept && !refuse && cmd.op != FSG_OP_SECSET;

  // One response per command: at once for refusals and settings, on completion otherwise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp <= '0;
    end else begin
      resp.valid <= (accept && !execOp) || (state == ST_EXEC && flashDone);
      resp.error <= accept ? refuse : (state == ST_EXEC && flashDone && !flashOk);
    end
  end

  // Latched settings follow the store only at entry; erase clears apply at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active <= LOCK_RESET;
    end else if (entryRise) begin
      active <= stored;
    end else if (clearEraseLocks && !active[LOCK_CHIP]) begin
      active[LOCK_BLOCK] <= 1'b0;
      active[LOCK_WRITE] <= 1'b0;
    end
  end

  // Interrupt events
  assign irqEvent[IRQ_REFUSED] = accept && refuse;
  assign irqEvent[IRQ_DONE]    = state == ST_EXEC && flashDone;
  assign irqEvent[IRQ_LOCKSET] = |setMask;

  // APB: one wait state, answer on the second access cycle
  assign apbAccess = psel && penable && !pready;
  assign apbCommit = psel && penable && pready;
  assign apbHit    = paddr == OFF_STATUS || paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RDATA_RESET;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess && !apbHit;
      prdata  <= RDATA_RESET;
      if (apbAccess && !pwrite) begin
        case (paddr)
          OFF_STATUS: begin
            prdata[STAT_ACTIVE_LSB +: 4] <= active;
            prdata[STAT_STORED_LSB +: 4] <= stored;
            prdata[STAT_BUSY_BIT]        <= state == ST_EXEC;
          end
          OFF_IRQ_STAT: prdata[2:0] <= irqStat;
          OFF_IRQ_MASK: prdata[2:0] <= irqMask;
          default:      prdata      <= RDATA_RESET;
        endcase
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat <= IRQ_RESET;
    end else if (apbCommit && pwrite && paddr == OFF_IRQ_STAT) begin
      irqStat <= (irqStat & ~pwdata[2:0]) | irqEvent;
    end else begin
      irqStat <= irqStat | irqEvent;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask <= IRQ_RESET;
    end else if (apbCommit && pwrite && paddr == OFF_IRQ_MASK) begin
      irqMask <= pwdata[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

  // Checks
  sequence s_refused;
    resp.valid && resp.error && !flashReq.go;
  endsequence

  sequence s_launched;
    flashReq.go && !resp.valid;
  endsequence

  a_chip_lock_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && !cmd.selfPath && active[LOCK_CHIP] && cmd.op inside {FSG_OP_CHIP, FSG_OP_BLOCK}
    |=> s_refused)
    else $error("erase passed under chip lock");

  a_block_lock_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && !cmd.selfPath && active[LOCK_BLOCK] && cmd.op == FSG_OP_BLOCK |=> s_refused)
    else $error("block erase passed under block lock");

  a_self_block_spared: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && cmd.selfPath && cmd.op == FSG_OP_BLOCK && !bootHit |=> s_launched)
    else $error("self block erase blocked");

  a_write_lock_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && !cmd.selfPath && active[LOCK_WRITE] && cmd.op inside {FSG_OP_WRITE, FSG_OP_BLOCK}
    |=> s_refused)
    else $error("write passed under write lock");

  a_self_write_spared: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && cmd.selfPath && cmd.op == FSG_OP_WRITE && !(active[LOCK_BOOT] && bootHit)
    |=> s_launched)
    else $error("self write blocked");

  a_boot_region_guard: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && active[LOCK_BOOT] && (cmd.op == FSG_OP_CHIP
    || (cmd.op inside {FSG_OP_BLOCK, FSG_OP_WRITE} && bootHit)) |=> s_refused)
    else $error("boot region touched under boot lock");

  a_chip_erase_allowed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && !cmd.selfPath && cmd.op == FSG_OP_CHIP && !active[LOCK_CHIP] && !active[LOCK_BOOT]
    |=> s_launched)
    else $error("chip erase refused without lock");

  a_settings_deferred: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !entryRise && !clearEraseLocks |=> active == $past(active))
    else $error("latched settings changed outside entry");

  a_erase_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearEraseLocks && !stored[LOCK_CHIP]
    |=> !stored[LOCK_BLOCK] && !stored[LOCK_WRITE] && stored[LOCK_BOOT] == $past(stored[LOCK_BOOT]))
    else $error("chip erase did not clear erase locks");

  // A command taken right after a refusal may launch; only that one may raise go
  a_refused_error: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && refuse |=> s_refused ##1 (flashReq.go == $past(execOp)))
    else $error("refused command reached flash");

  a_refused_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && refuse |=> state == ST_IDLE && cmdReady)
    else $error("refused command left gate busy");

  a_self_chip_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept && cmd.selfPath && cmd.op == FSG_OP_CHIP |=> s_refused)
    else $error("self path chip erase executed");

  // Entry reload has priority, so a clear in that cycle is not judged here
  a_active_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearEraseLocks && !active[LOCK_CHIP] && !entryRise
    |=> !active[LOCK_BLOCK] && !active[LOCK_WRITE])
    else $error("latched erase locks survived chip erase");
endmodule
`default_nettype wire

// [sim/fsg_flash_model.sv]
// Flash cell engine model that answers gate requests, alternately fast and slow
`timescale 1ns/1ps
`default_nettype none
module fsg_flash_model
  import fsg_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  // Request and completion
  input  wire fsg_flash_type flashReq,
  output logic               flashDone,
  output logic               flashOk
);
  logic [3:0] waitCnt;
  logic       busy;
  logic       slow;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      slow      <= 1'b0;
      waitCnt   <= 4'h0;
      flashDone <= 1'b0;
      flashOk   <= 1'b0;
    end else begin
      flashDone <= 1'b0;
      // Status carries no meaning outside the done pulse, so it toggles every cycle except where the done pulse forces it high
      flashOk   <= ~flashOk;
      if (flashReq.go) begin
        busy    <= 1'b1;
        waitCnt <= slow ? 4'h6 : 4'h0;
        slow    <= ~slow;
      end else if (busy && waitCnt == 4'h0) begin
        busy      <= 1'b0;
        flashDone <= 1'b1;
        flashOk   <= 1'b1;
      end else if (busy) begin
        waitCnt <= waitCnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/flash_security_gate_tb.sv]
// Self-checking bench for the flash security gate
`timescale 1ns/1ps
`default_nettype none
module flash_security_gate_tb
  import fsg_pkg::*;
;
  logic          sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata;
  logic          progEntryPin, cmdValid, cmdReady, flashDone, flashOk, irq;
  fsg_cmd_type   cmd;
  fsg_resp_type  resp;
  fsg_flash_type flashReq;
  int            miscompares, check_count, goCount;
  fsg_op_type    goOp;
  logic [15:0]   goAddr;

  fsg_gate dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progEntryPin(progEntryPin), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .resp(resp),
    .flashReq(flashReq), .flashDone(flashDone), .flashOk(flashOk), .irq(irq));
  fsg_flash_model flash_u (.sys_clk(sys_clk), .rst_b(rst_b), .flashReq(flashReq),
    .flashDone(flashDone), .flashOk(flashOk));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (flashReq.go === 1'b1) begin
      goCount <= goCount + 1;
      goOp    <= flashReq.op;
      goAddr  <= flashReq.addr;
    end
  end

  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    final_report();
  endtask

  task automatic chk_bit(input logic act, input logic exp, input string msg);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %b", $time, msg, act);
    end
  endtask

  task automatic chk_reg(input logic [31:0] act, input logic [31:0] exp, input string msg);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, act, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk_bit(e, 1'b0, "write error");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk_bit(e, 1'b0, "read error");
    chk_reg(r, exp, "register read");
  endtask

  function automatic logic [31:0] st(input logic [3:0] act, input logic [3:0] stor);
    return (32'(act) << STAT_ACTIVE_LSB) | (32'(stor) << STAT_STORED_LSB);
  endfunction

  // Offers one command, waits for the response, judges error and flash launch
  task automatic do_cmd(input logic s, input fsg_op_type o, input logic [15:0] a,
                        input logic [3:0] l, input logic expErr);
    int n;
    int g0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 50);
    if (cmdReady !== 1'b1) give_up();
    g0 = goCount;
    cmdValid <= 1'b1;
    cmd      <= '{s, o, a, l};
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (resp.valid !== 1'b1 && n < 50);
    if (resp.valid !== 1'b1) give_up();
    chk_bit(resp.error, expErr, "response error");
    @(posedge sys_clk);
    chk_bit(goCount != g0, !expErr && o != FSG_OP_SECSET, "flash launch");
    if (!expErr && o != FSG_OP_SECSET) begin
      chk_reg({14'h0000, goOp, goAddr}, {14'h0000, o, a}, "flash request");
    end
  endtask

  task automatic enter();
    @(posedge sys_clk);
    progEntryPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    progEntryPin <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic sc_reset();
    logic [31:0] r;
    logic        e;
    rd_chk(OFF_STATUS, st(4'h0, 4'h0));
    rd_chk(OFF_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000, r, e);
    chk_bit(e, 1'b1, "unmapped error");
    chk_reg(r, 32'h0000_0000, "unmapped data");
    do_cmd(1'b0, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b0);
    do_cmd(1'b0, FSG_OP_WRITE, 16'h0000, 4'h0, 1'b0);
  endtask

  task automatic sc_erase_locks();
    do_cmd(1'b1, FSG_OP_SECSET, 16'h0000, 4'h6, 1'b0);
    rd_chk(OFF_STATUS, st(4'h0, 4'h6));
    do_cmd(1'b0, FSG_OP_BLOCK, 16'h2000, 4'h0, 1'b0);
    enter();
    rd_chk(OFF_STATUS, st(4'h6, 4'h6));
    do_cmd(1'b0, FSG_OP_BLOCK, 16'h2000, 4'h0, 1'b1);
    do_cmd(1'b0, FSG_OP_WRITE, 16'h2000, 4'h0, 1'b1);
    do_cmd(1'b1, FSG_OP_BLOCK, 16'h2000, 4'h0, 1'b0);
    do_cmd(1'b1, FSG_OP_WRITE, 16'h2000, 4'h0, 1'b0);
    do_cmd(1'b0, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b0);
    rd_chk(OFF_STATUS, st(4'h0, 4'h0));
  endtask

  task automatic sc_self_clear();
    do_cmd(1'b0, FSG_OP_SECSET, 16'h0000, 4'h4, 1'b0);
    enter();
    do_cmd(1'b0, FSG_OP_BLOCK, 16'h4000, 4'h0, 1'b1);
    do_cmd(1'b1, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b1);
    rd_chk(OFF_STATUS, st(4'h4, 4'h4));
    do_cmd(1'b0, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b0);
    rd_chk(OFF_STATUS, st(4'h0, 4'h0));
    // Block lock alone, so its refusal is not masked by the write lock
    do_cmd(1'b0, FSG_OP_SECSET, 16'h0000, 4'h2, 1'b0);
    enter();
    do_cmd(1'b0, FSG_OP_BLOCK, 16'h6000, 4'h0, 1'b1);
    do_cmd(1'b0, FSG_OP_WRITE, 16'h6000, 4'h0, 1'b0);
    do_cmd(1'b0, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b0);
    rd_chk(OFF_STATUS, st(4'h0, 4'h0));
  endtask

  task automatic sc_irq();
    wr(OFF_IRQ_STAT, 32'h0000_0007);
    rd_chk(OFF_IRQ_STAT, 32'h0000_0000);
    wr(OFF_IRQ_MASK, 32'h0000_0001 << IRQ_REFUSED);
    rd_chk(OFF_IRQ_MASK, 32'h0000_0001 << IRQ_REFUSED);
    // A finished flash operation is masked off and must stay quiet
    do_cmd(1'b0, FSG_OP_WRITE, 16'h5000, 4'h0, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b0, "masked event");
    do_cmd(1'b1, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b1, "refusal interrupt");
    rd_chk(OFF_IRQ_STAT, (32'h1 << IRQ_REFUSED) | (32'h1 << IRQ_DONE));
    wr(OFF_IRQ_STAT, 32'h0000_0001 << IRQ_REFUSED);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b0, "interrupt cleared");
    rd_chk(OFF_IRQ_STAT, 32'h0000_0001 << IRQ_DONE);
  endtask

  task automatic sc_boot();
    do_cmd(1'b0, FSG_OP_SECSET, 16'h0000, 4'h8, 1'b0);
    rd_chk(OFF_IRQ_STAT, (32'h1 << IRQ_DONE) | (32'h1 << IRQ_LOCKSET));
    enter();
    do_cmd(1'b0, FSG_OP_WRITE, BOOT_LAST, 4'h0, 1'b1);
    do_cmd(1'b0, FSG_OP_WRITE, 16'h1000, 4'h0, 1'b0);
    do_cmd(1'b0, FSG_OP_BLOCK, 16'h0000, 4'h0, 1'b1);
    do_cmd(1'b0, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b1);
    do_cmd(1'b1, FSG_OP_WRITE, BOOT_LAST, 4'h0, 1'b1);
    do_cmd(1'b1, FSG_OP_BLOCK, 16'h0800, 4'h0, 1'b1);
    do_cmd(1'b1, FSG_OP_BLOCK, 16'h1000, 4'h0, 1'b0);
    rd_chk(OFF_STATUS, st(4'h8, 4'h8));
  endtask

  // Chip lock is permanent, so this runs last
  task automatic sc_chip();
    do_cmd(1'b1, FSG_OP_SECSET, 16'h0000, 4'h1, 1'b0);
    enter();
    do_cmd(1'b0, FSG_OP_CHIP, 16'h0000, 4'h0, 1'b1);
    do_cmd(1'b0, FSG_OP_BLOCK, 16'h2000, 4'h0, 1'b1);
    do_cmd(1'b0, FSG_OP_WRITE, 16'h3000, 4'h0, 1'b0);
    do_cmd(1'b0, FSG_OP_SECSET, 16'h0000, 4'h0, 1'b0);
    enter();
    rd_chk(OFF_STATUS, st(4'h9, 4'h9));
  endtask

  initial begin
    miscompares  = 0;
    check_count  = 0;
    goCount      = 0;
    rst_b        = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0000_0000;
    progEntryPin = 1'b0;
    cmdValid     = 1'b0;
    cmd          = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    sc_reset();
    sc_erase_locks();
    sc_self_clear();
    sc_irq();
    sc_boot();
    sc_chip();
    final_report();
  end
endmodule
`default_nettype wire
